// ### design/ncm_pkg.sv
/*
  Constants shared by the oscillator-mixer: widths, the default
  decode of the destination select, configuration word fields and
  reset values.
  Assumes a single system clock and synchronous control inputs.
*/
// Notes on behaviour
// - a 32-bit phase accumulator is the argument for sine and cosine.
// - the oscillator (cos, sin) multiplies the input vector, 16-bit each.
// - successive complex products may be summed inside for accumulate-dump.
// - real and imaginary results leave by two separate 20-bit ports.
// - bit position and width of the result fields are programmable.
// - with a center frequency loaded, input samples are mixed down.
// - host drives a 16-bit control word, bit 15 most significant.
// - a 2-bit select, bit 1 most significant, picks the register.
// - word captured at write strobe rising edge while chip select is low.
// - all other registers move at clock edges; input flops every edge, the data path only when enabled.
// - phase load enable is registered first, then lets the phase load.
package ncm_pkg;
  localparam int PHASE_W = 32;
  localparam int CTRL_W  = 16;
  localparam int DATA_W  = 16;
  localparam int OUT_W   = 20;
  localparam int PROD_W  = 33;
  localparam int ACC_W   = 40;
  localparam int ROM_AW  = 6;
  localparam int FIFO_D  = 8;

  // default select codes for each control destination
  localparam logic [1:0] DEST_FREQ_LO = 2'h0;
  localparam logic [1:0] DEST_FREQ_HI = 2'h1;
  localparam logic [1:0] DEST_PHASE   = 2'h2;
  localparam logic [1:0] DEST_CFG     = 2'h3;

  // configuration word fields
  localparam int CFG_SHIFT_LSB = 0;
  localparam int CFG_SHIFT_W   = 5;
  localparam int CFG_WIDTH_LSB = 5;
  localparam int CFG_WIDTH_W   = 2;
  localparam int CFG_ACCUM_BIT = 7;
  localparam int CFG_CONJ_BIT  = 8;
  localparam logic [CFG_SHIFT_W-1:0] SHIFT_MAX = 5'h14;

  // reset values
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 16'h0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 32'h0000_0000;
  localparam logic [OUT_W-1:0]   OUT_RST   = 20'h00000;
  localparam logic [ACC_W-1:0]   ACC_RST   = 40'h00_0000_0000;
endpackage

// ### design/ncm_fifo.sv
/*
  Sample FIFO with valid/ready at both ends; width and depth are
  parameters. Depth must be a power of two. Room and empty are flops,
  so write ready comes straight from a register.
*/
`timescale 1ns/1ns
`default_nettype none
module ncm_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  input  wire logic [W-1:0] wr_data_i,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [W-1:0]      rd_data_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          room_r, room_nxt, empty_r, empty_nxt;
  logic          do_wr, do_rd;
  logic [W-1:0]  mem_r [D];

  always_comb begin
    do_wr      = wr_valid_i & room_r;
    do_rd      = rd_ready_i & ~empty_r;
    wr_ptr_nxt = do_wr ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = do_rd ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    cnt_nxt    = CW'(cnt_r + CW'(do_wr) - CW'(do_rd));
    room_nxt   = (cnt_nxt != CW'(D));
    empty_nxt  = (cnt_nxt == '0);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      room_r   <= 1'b1;
      empty_r  <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
      room_r   <= room_nxt;
      empty_r  <= empty_nxt;
    end
  end

  // storage has no reset; entries are only read once written
  for (genvar e = 0; e < D; e++) begin : g_entry
    always_ff @(posedge clk_sys_i) begin
      if (do_wr && wr_ptr_r == AW'(e)) begin
        mem_r[e] <= wr_data_i;
      end
    end
  end

  assign wr_ready_o = room_r;
  assign rd_valid_o = ~empty_r;
  assign rd_data_o  = mem_r[rd_ptr_r];
endmodule
`default_nettype wire

// ### design/ncm_sincos_rom.sv
/*
  Sine/cosine table: 64 phase steps per turn from a 17-entry quarter
  wave. Outputs are registered and move only while rd_en_i is high.
*/
`timescale 1ns/1ns
`default_nettype none
module ncm_sincos_rom (
  input  wire logic                       clk_sys_i,
  input  wire logic                       resetn_i,
  input  wire logic                       rd_en_i,
  input  wire logic [ncm_pkg::ROM_AW-1:0] phase_i,
  output logic [ncm_pkg::DATA_W-1:0]      cos_o,
  output logic [ncm_pkg::DATA_W-1:0]      sin_o
);
  logic [15:0] cos_r, cos_nxt, sin_r, sin_nxt;

  function automatic logic [15:0] quarter(input logic [4:0] k);
    case (k)
      5'h00:   quarter = 16'h0000;
      5'h01:   quarter = 16'h0C8C;
      5'h02:   quarter = 16'h18F9;
      5'h03:   quarter = 16'h2528;
      5'h04:   quarter = 16'h30FB;
      5'h05:   quarter = 16'h3C56;
      5'h06:   quarter = 16'h471C;
      5'h07:   quarter = 16'h5133;
      5'h08:   quarter = 16'h5A82;
      5'h09:   quarter = 16'h62F1;
      5'h0A:   quarter = 16'h6A6D;
      5'h0B:   quarter = 16'h70E2;
      5'h0C:   quarter = 16'h7641;
      5'h0D:   quarter = 16'h7A7C;
      5'h0E:   quarter = 16'h7D89;
      5'h0F:   quarter = 16'h7F61;
      default: quarter = 16'h7FFF;
    endcase
  endfunction

  // full-scale is 7FFF so negation never overflows
  function automatic logic [15:0] sine(input logic [5:0] p);
    logic [4:0]  i;
    logic [15:0] m;
    i = {1'b0, p[3:0]};
    m = p[4] ? quarter(5'h10 - i) : quarter(i);
    sine = p[5] ? 16'(-m) : m;
  endfunction

  always_comb begin
    cos_nxt = rd_en_i ? sine(6'(phase_i + 6'h10)) : cos_r;
    sin_nxt = rd_en_i ? sine(phase_i) : sin_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cos_r <= 16'h0000;
      sin_r <= 16'h0000;
    end else begin
      cos_r <= cos_nxt;
      sin_r <= sin_nxt;
    end
  end

  assign cos_o = cos_r;
  assign sin_o = sin_r;
endmodule
`default_nettype wire

// ### design/ncm_mixer.sv
/*
  Oscillator and complex multiplier-accumulator. Host control words
  come in over a 16-bit bus with write strobe; samples enter a FIFO,
  are rotated by the oscillator vector and leave as 20-bit parts.
  Assumes every input is synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module ncm_mixer #(
  parameter logic [1:0] CODE_FREQ_LO = ncm_pkg::DEST_FREQ_LO,
  parameter logic [1:0] CODE_FREQ_HI = ncm_pkg::DEST_FREQ_HI,
  parameter logic [1:0] CODE_PHASE   = ncm_pkg::DEST_PHASE,
  parameter logic [1:0] CODE_CFG     = ncm_pkg::DEST_CFG
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       resetn_i,
  input  wire logic [ncm_pkg::CTRL_W-1:0] ctrl_in_bus_i,
  input  wire logic [1:0]                 dest_select_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       wr_i,
  input  wire logic                       phase_reg_load_en_n_i,
  input  wire logic                       acc_dump_n_i,
  input  wire logic [ncm_pkg::DATA_W-1:0] in_real_i,
  input  wire logic [ncm_pkg::DATA_W-1:0] in_imag_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  output logic [ncm_pkg::OUT_W-1:0]       out_real_o,
  output logic [ncm_pkg::OUT_W-1:0]       out_imag_o,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i
);
  // control words written by the host
  logic [15:0] freq_lo_r, freq_lo_nxt, freq_hi_r, freq_hi_nxt;
  logic [15:0] phase_word_r, phase_word_nxt, cfg_r, cfg_nxt;
  logic        wr_d_r, wr_rise;

  // the strobe is sampled; a rising edge with chip select low writes
  always_comb begin
    wr_rise        = wr_i & ~wr_d_r & ~cs_n_i;
    freq_lo_nxt    = freq_lo_r;
    freq_hi_nxt    = freq_hi_r;
    phase_word_nxt = phase_word_r;
    cfg_nxt        = cfg_r;
    if (wr_rise) begin
      // first matching code wins if two codes collide
      if (dest_select_i == CODE_FREQ_LO) begin
        freq_lo_nxt = ctrl_in_bus_i;
      end else if (dest_select_i == CODE_FREQ_HI) begin
        freq_hi_nxt = ctrl_in_bus_i;
      end else if (dest_select_i == CODE_PHASE) begin
        phase_word_nxt = ctrl_in_bus_i;
      end else if (dest_select_i == CODE_CFG) begin
        cfg_nxt = ctrl_in_bus_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_d_r       <= 1'b0;
      freq_lo_r    <= ncm_pkg::CTRL_RST;
      freq_hi_r    <= ncm_pkg::CTRL_RST;
      phase_word_r <= ncm_pkg::CTRL_RST;
      cfg_r        <= ncm_pkg::CTRL_RST;
    end else begin
      wr_d_r       <= wr_i;
      freq_lo_r    <= freq_lo_nxt;
      freq_hi_r    <= freq_hi_nxt;
      phase_word_r <= phase_word_nxt;
      cfg_r        <= cfg_nxt;
    end
  end

  // configuration fields
  logic [4:0]  cfg_shift, shift_amt;
  logic [1:0]  cfg_width;
  logic        cfg_accum, cfg_conj;
  logic [31:0] freq_word;

  always_comb begin
    cfg_shift = cfg_r[ncm_pkg::CFG_SHIFT_LSB +: ncm_pkg::CFG_SHIFT_W];
    cfg_width = cfg_r[ncm_pkg::CFG_WIDTH_LSB +: ncm_pkg::CFG_WIDTH_W];
    cfg_accum = cfg_r[ncm_pkg::CFG_ACCUM_BIT];
    cfg_conj  = cfg_r[ncm_pkg::CFG_CONJ_BIT];
    // a shift past the top would leave only sign bits
    shift_amt = (cfg_shift > ncm_pkg::SHIFT_MAX) ? ncm_pkg::SHIFT_MAX
                                                 : cfg_shift;
    freq_word = {freq_hi_r, freq_lo_r};
  end

  // flow control: the output stage stalls the whole pipe
  logic        go, pop, fifo_valid;
  logic [31:0] fifo_data;

  ncm_fifo #(
    .W (2 * ncm_pkg::DATA_W),
    .D (ncm_pkg::FIFO_D)
  ) u_fifo (
    .clk_sys_i  (clk_sys_i),
    .resetn_i   (resetn_i),
    .wr_valid_i (in_valid_i),
    .wr_ready_o (in_ready_o),
    .wr_data_i  ({in_real_i, in_imag_i}),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (go),
    .rd_data_o  (fifo_data)
  );

  // phase section
  logic        phen_n_r;
  logic [15:0] phase_r, phase_nxt;
  logic [31:0] phacc_r, phacc_nxt, phase_arg;

  always_comb begin
    go  = ~out_valid_o | out_ready_i;
    pop = go & fifo_valid;
    // loading waits for the registered enable, not the pin itself
    phase_nxt = phen_n_r ? phase_r : phase_word_r;
    // phase steps once per sample taken, so it tracks the sample rate
    phacc_nxt = pop ? 32'(phacc_r + freq_word) : phacc_r;
    phase_arg = 32'(phacc_r + {phase_r, 16'h0000});
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phen_n_r <= 1'b1;
      phase_r  <= ncm_pkg::CTRL_RST;
      phacc_r  <= ncm_pkg::PHASE_RST;
    end else begin
      phen_n_r <= phase_reg_load_en_n_i;
      phase_r  <= phase_nxt;
      phacc_r  <= phacc_nxt;
    end
  end

  logic [15:0] cos_q, sin_q;

  ncm_sincos_rom u_rom (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .rd_en_i   (pop),
    .phase_i   (phase_arg[31 -: ncm_pkg::ROM_AW]),
    .cos_o     (cos_q),
    .sin_o     (sin_q)
  );

  // first stage holds the sample beside the table's registered output
  logic        s1_valid_r, s1_valid_nxt, dump_n_r;
  logic [15:0] s1_re_r, s1_re_nxt, s1_im_r, s1_im_nxt;

  always_comb begin
    s1_valid_nxt = go ? fifo_valid : s1_valid_r;
    s1_re_nxt    = pop ? fifo_data[31:16] : s1_re_r;
    s1_im_nxt    = pop ? fifo_data[15:0] : s1_im_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_valid_r <= 1'b0;
      s1_re_r    <= 16'h0000;
      s1_im_r    <= 16'h0000;
      dump_n_r   <= 1'b1;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      s1_re_r    <= s1_re_nxt;
      s1_im_r    <= s1_im_nxt;
      dump_n_r   <= acc_dump_n_i;
    end
  end

  // complex multiply; conjugate mode mixes down with a positive tuning
  logic signed [31:0] m_rc, m_is, m_rs, m_ic;
  logic [32:0]        prod_re, prod_im;
  logic [39:0]        ext_re, ext_im, sum_re, sum_im;
  logic [39:0]        acc_re_r, acc_re_nxt, acc_im_r, acc_im_nxt;
  logic               upd;

  always_comb begin
    m_rc = $signed(s1_re_r) * $signed(cos_q);
    m_is = $signed(s1_im_r) * $signed(sin_q);
    m_rs = $signed(s1_re_r) * $signed(sin_q);
    m_ic = $signed(s1_im_r) * $signed(cos_q);
    if (cfg_conj) begin
      prod_re = 33'({m_rc[31], m_rc} + {m_is[31], m_is});
      prod_im = 33'({m_ic[31], m_ic} - {m_rs[31], m_rs});
    end else begin
      prod_re = 33'({m_rc[31], m_rc} - {m_is[31], m_is});
      prod_im = 33'({m_ic[31], m_ic} + {m_rs[31], m_rs});
    end
    ext_re = {{7{prod_re[32]}}, prod_re};
    ext_im = {{7{prod_im[32]}}, prod_im};
    // dump restarts the sum from the present product
    if (cfg_accum && dump_n_r) begin
      sum_re = 40'(acc_re_r + ext_re);
      sum_im = 40'(acc_im_r + ext_im);
    end else begin
      sum_re = ext_re;
      sum_im = ext_im;
    end
    upd        = go & s1_valid_r;
    acc_re_nxt = upd ? sum_re : acc_re_r;
    acc_im_nxt = upd ? sum_im : acc_im_r;
  end

  // field select: arithmetic shift, then keep the top bits by width
  function automatic logic [19:0] field(input logic [39:0] v,
                                        input logic [4:0]  sh,
                                        input logic [1:0]  wd);
    logic [39:0] s;
    logic [19:0] mask;
    s = 40'($signed(v) >>> sh);
    case (wd)
      2'h0:    mask = 20'hFFFFF;
      2'h1:    mask = 20'hFFFF0;
      2'h2:    mask = 20'hFFF00;
      default: mask = 20'hFF000;
    endcase
    field = s[19:0] & mask;
  endfunction

  logic [19:0] out_re_r, out_re_nxt, out_im_r, out_im_nxt;
  logic        out_valid_r, out_valid_nxt;

  always_comb begin
    out_valid_nxt = go ? s1_valid_r : out_valid_r;
    out_re_nxt = upd ? field(sum_re, shift_amt, cfg_width) : out_re_r;
    out_im_nxt = upd ? field(sum_im, shift_amt, cfg_width) : out_im_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_re_r    <= ncm_pkg::ACC_RST;
      acc_im_r    <= ncm_pkg::ACC_RST;
      out_re_r    <= ncm_pkg::OUT_RST;
      out_im_r    <= ncm_pkg::OUT_RST;
      out_valid_r <= 1'b0;
    end else begin
      acc_re_r    <= acc_re_nxt;
      acc_im_r    <= acc_im_nxt;
      out_re_r    <= out_re_nxt;
      out_im_r    <= out_im_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  assign out_real_o  = out_re_r;
  assign out_imag_o  = out_im_r;
  assign out_valid_o = out_valid_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  phase_step_a: assert property (
    pop |=> phacc_r == 32'($past(phacc_r) + $past(freq_word)))
    else $error("phase accumulator did not step by frequency");

  phase_hold_a: assert property (
    !pop |=> $stable(phacc_r))
    else $error("phase accumulator moved without a sample");

  ctrl_write_a: assert property (
    wr_rise && dest_select_i == CODE_FREQ_LO
      |=> freq_lo_r == $past(ctrl_in_bus_i))
    else $error("control word not captured at strobe edge");

  cs_block_a: assert property (
    cs_n_i |=> $stable({freq_lo_r, freq_hi_r, phase_word_r, cfg_r}))
    else $error("control register written without chip select");

  phase_load_a: assert property (
    !phase_reg_load_en_n_i |=> ##1 phase_r == $past(phase_word_r))
    else $error("phase register not loaded after enable");

  phase_keep_a: assert property (
    phase_reg_load_en_n_i |=> ##1 phase_r == $past(phase_r))
    else $error("phase register loaded without registered enable");

  out_stall_a: assert property (
    out_valid_r && !out_ready_i |=> out_valid_r && $stable(out_re_r)
      && $stable(out_im_r))
    else $error("output changed while stalled");

  mult_out_a: assert property (
    upd && !cfg_accum && cfg_shift == 5'h00 && cfg_width == 2'h0
      |=> out_re_r == $past(prod_re[19:0]))
    else $error("real output does not match product");

  accum_sum_a: assert property (
    upd && cfg_accum && dump_n_r
      |=> acc_im_r == 40'($past(acc_im_r) + $past(ext_im)))
    else $error("accumulator did not add the product");

  pipe_flow_a: assert property (
    pop ##1 go |=> out_valid_r)
    else $error("sample taken but no result followed");
endmodule
`default_nettype wire

// ### tb/ncm_sink.sv
/*
  Far end of the result stream: a ready source that can stall.
  Assumes mode_i is driven by the bench just after clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module ncm_sink (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] mode_i,
  output logic            ready_o
);
  logic go_nxt;
  logic coin_r;

  // mode 0 always ready, 1 random stalls, 2 held off to back up the fifo
  always_comb begin
    go_nxt = 1'b0;
    if (mode_i == 2'h0) begin
      go_nxt = 1'b1;
    end else if (mode_i == 2'h1) begin
      go_nxt = coin_r;
    end
  end

  // fresh draw every clock; a draw in always_comb would never rerun
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      coin_r  <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      coin_r  <= 1'($urandom_range(1, 0));
      ready_o <= go_nxt;
    end
  end
endmodule
`default_nettype wire

// ### tb/ncm_mixer_test.sv
/*
  Bench for the oscillator mixer: host writes, sample bursts and a
  queue model checked at every result. Assumes ncm_sink as far end.
*/
`timescale 1ns/1ns
`default_nettype none
module ncm_mixer_test;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [15:0] bus       = 16'h0000;
  logic [1:0]  sel       = 2'h0;
  logic        cs_n      = 1'b1;
  logic        wr        = 1'b0;
  logic        phen_n    = 1'b1;
  logic        dump_n    = 1'b1;
  logic [15:0] ir        = 16'h0000;
  logic [15:0] iq        = 16'h0000;
  logic        iv        = 1'b0;
  logic [1:0]  mode      = 2'h0;
  logic        in_ready_o;
  logic        out_valid_o;
  logic        out_ready;
  logic [19:0] out_real_o;
  logic [19:0] out_imag_o;
  logic [31:0] m_freq    = 32'h0000_0000;
  logic [31:0] m_osc     = 32'h0000_0000;
  logic [15:0] m_phw     = 16'h0000;
  logic [15:0] m_phr     = 16'h0000;
  logic [15:0] m_cfg     = 16'h0000;
  longint      m_sr      = 0;
  longint      m_si      = 0;
  logic [19:0] eq_re[$];
  logic [19:0] eq_im[$];
  int          num_errors      = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  int          n;
  logic        r;
  logic [31:0] d;

  ncm_mixer ncm_mixer_i (
    .clk_sys_i            (clk_sys_i),
    .resetn_i             (resetn_i),
    .ctrl_in_bus_i        (bus),
    .dest_select_i        (sel),
    .cs_n_i               (cs_n),
    .wr_i                 (wr),
    .phase_reg_load_en_n_i(phen_n),
    .acc_dump_n_i         (dump_n),
    .in_real_i            (ir),
    .in_imag_i            (iq),
    .in_valid_i           (iv),
    .in_ready_o           (in_ready_o),
    .out_real_o           (out_real_o),
    .out_imag_o           (out_imag_o),
    .out_valid_o          (out_valid_o),
    .out_ready_i          (out_ready)
  );

  ncm_sink ncm_sink_i (
    .clk_sys_i(clk_sys_i),
    .resetn_i (resetn_i),
    .mode_i   (mode),
    .ready_o  (out_ready)
  );

  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] s);
    samples_checked++;
    if (e !== s) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // quarter-turn phases only, so table entries are exact full scale
  function automatic longint cosv(input logic [5:0] i);
    if (i[4]) begin
      return 0;
    end
    return i[5] ? -64'sh7FFF : 64'sh7FFF;
  endfunction

  function automatic logic [19:0] fld(input longint v);
    longint t;
    int     sh;
    sh = (m_cfg[4:0] > 5'h14) ? 20 : int'(m_cfg[4:0]);
    t  = v >>> sh;
    return t[19:0] & (20'hFFFFF << (4 * m_cfg[6:5]));
  endfunction

  task automatic model(input logic [15:0] re, input logic [15:0] im);
    logic [31:0] arg;
    longint      c, s, a, b, pr, pm;
    arg   = m_osc + {m_phr, 16'h0000};
    m_osc = m_osc + m_freq;
    c  = cosv(arg[31:26]);
    s  = cosv(arg[31:26] - 6'h10);
    a  = longint'($signed(re));
    b  = longint'($signed(im));
    pr = m_cfg[8] ? a * c + b * s : a * c - b * s;
    pm = m_cfg[8] ? b * c - a * s : b * c + a * s;
    if (m_cfg[7] && dump_n) begin
      m_sr = m_sr + pr;
      m_si = m_si + pm;
    end else begin
      m_sr = pr;
      m_si = pm;
    end
    eq_re.push_back(fld(m_sr));
    eq_im.push_back(fld(m_si));
  endtask

  // wr low for a sampled cycle before each rise, so every call with c low is a write
  task automatic wr_word(input logic [1:0] a, input logic [15:0] w,
                         input logic c);
    @(posedge clk_sys_i);
    cs_n <= c;
    sel  <= a;
    bus  <= w;
    wr   <= 1'b1;
    @(posedge clk_sys_i);
    wr   <= 1'b0;
    cs_n <= 1'b1;
    if (!c) begin
      case (a)
        2'h0: m_freq[15:0] = w;
        2'h1: m_freq[31:16] = w;
        2'h2: m_phw = w;
        default: m_cfg = w;
      endcase
    end
  endtask

  task automatic push(input logic [15:0] re, input logic [15:0] im);
    logic rr;
    model(re, im);
    ir <= re;
    iq <= im;
    iv <= 1'b1;
    forever begin
      @(negedge clk_sys_i);
      rr = in_ready_o;
      @(posedge clk_sys_i);
      if (rr) break;
    end
  endtask

  task automatic burst(input int k);
    logic [31:0] v;
    @(posedge clk_sys_i);
    repeat (k) begin
      v = $urandom;
      push(v[15:0], v[31:16]);
    end
    iv <= 1'b0;
    repeat (300) begin
      if (eq_re.size() == 0) break;
      @(posedge clk_sys_i);
    end
    chk("drain", 20'h00000, 20'(eq_re.size()));
  endtask

  always @(negedge clk_sys_i) begin
    if (out_valid_o === 1'b1 && out_ready === 1'b1) begin
      if (eq_re.size() == 0) begin
        chk("extra", 20'h00000, 20'hFFFFF);
      end else begin
        chk("out_real", eq_re.pop_front(), out_real_o);
        chk("out_imag", eq_im.pop_front(), out_imag_o);
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    d = $urandom(32'h3193);
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("rst_ready", 20'h00001, 20'(in_ready_o));
    chk("rst_valid", 20'h00000, 20'(out_valid_o));
    chk("rst_real", 20'h00000, out_real_o);
    wr_word(2'h1, 16'h4000, 1'b1);
    burst(3);
    mode <= 2'h1;
    for (int k = 0; k < 8; k++) begin
      d = (k == 7) ? 32'h18 : $urandom_range(20, 0);
      wr_word(2'h3, {7'h00, k[0], 1'b0, k[2:1], d[4:0]}, 1'b0);
      if (k == 2) wr_word(2'h0, 16'h0000, 1'b0);
      if (k == 3) wr_word(2'h1, 16'h4000, 1'b0);
      burst(6);
    end
    wr_word(2'h3, 16'h0084, 1'b0);
    burst(5);
    @(posedge clk_sys_i);
    dump_n <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    burst(3);
    dump_n <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    burst(3);
    wr_word(2'h3, 16'h0000, 1'b0);
    wr_word(2'h1, 16'h0000, 1'b0);
    wr_word(2'h2, 16'h4000, 1'b0);
    burst(2);
    @(posedge clk_sys_i);
    phen_n <= 1'b0;
    @(posedge clk_sys_i);
    phen_n <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    m_phr = m_phw;
    burst(3);
    // hold the far end off and fill until the input refuses
    mode <= 2'h2;
    n = 0;
    @(posedge clk_sys_i);
    repeat (14) begin
      d = $urandom;
      ir <= d[15:0];
      iq <= d[31:16];
      iv <= 1'b1;
      @(negedge clk_sys_i);
      r = in_ready_o;
      @(posedge clk_sys_i);
      if (r) begin
        model(d[15:0], d[31:16]);
        n++;
      end
    end
    iv <= 1'b0;
    chk("refused", 20'h00000, 20'(r));
    chk("fill", 20'h00001, 20'(n >= 8 && n <= 10));
    mode <= 2'h1;
    burst(1);
    test_done();
  end
endmodule
`default_nettype wire
